// *** src/timer8_dual_compare_pwm.sv ***
// 8-bit timer/counter with two compare channels and an apb register port
`timescale 1ns/1ns

// Behaviour
// - counter runs between bottom 0x00 and maximum 0xff
// - top is 0xff or compare register a, chosen by wave mode
// - clock select zero stops the counter, no ticks
// - tick from prescaler or synchronised external input edge
// - cpu may read and write the count at any time
// - cpu count write beats clear or count in the same cycle
// - each tick clears, increments or decrements per mode
// - wave mode is two bits in control a plus one in control b
// - overflow flag set at a mode dependent point, may request interrupt
// - compare match sets its flag on the next tick
// - servicing an interrupt clears its flag
// - writing one to a flag clears it; zero does nothing
// - mask register gates each of three sources; flags show all pending
// - compare registers double buffered in pwm modes only
// - buffered value moves to active compare only at top or bottom
// - cpu reaches buffer when buffering, else the active compare
// - force strobe updates output in non-pwm modes, no flag, no clear
// - match blocked on the tick after any cpu count write
// - output state survives switching wave modes
// - compare output mode changes act immediately
// - mode 0 counts up, wraps 0xff to 0x00, overflow as zero
// - mode 2 clears counter on match with compare register a
// - fast pwm single slope, top 0xff in mode 3, compare a in 7
// - compare output mode zero takes no action on match
module timer8_dual_compare_pwm #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_count_input,
  input wire logic [2:0] irq_ack,
  output logic [2:0] irq_req,
  output logic wave_out_a,
  output logic wave_out_b,
  output logic wave_oe_a,
  output logic wave_oe_b
);

  initial begin
    if (WIDTH != 8) $error("timer8_dual_compare_pwm: WIDTH must be 8");
  end

  // ****************************************
  // registers and state
  // ****************************************
  logic [7:0] ctrl_a_r;
  logic [2:0] clock_select_field_r;
  logic wave_mode_bit2_r;
  logic [7:0] count_value_r;
  logic [2:0] irq_mask_reg_r;
  logic [2:0] irq_flag_reg_r;
  logic [2:0] irq_flag_nxt;
  logic timer_power_reduce_bit_r;
  logic down_r;
  logic block_r;
  logic [9:0] pre_r;
  logic ext_meta_r;
  logic ext_sync_r;
  logic ext_prev_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic [2:0] irq_req_r;
  logic wave_oe_a_r;
  logic wave_oe_b_r;

  // ****************************************
  // bus decode
  // ****************************************
  logic setup;
  logic wr_fire;
  logic mapped;
  logic wr_ctrl_a;
  logic wr_ctrl_b;
  logic wr_count;
  logic wr_cmp_a;
  logic wr_cmp_b;
  logic wr_mask;
  logic wr_flag;
  logic wr_power;

  assign setup = psel && !penable;
  assign wr_fire = psel && penable && pready_r && pwrite;
  assign wr_ctrl_a = wr_fire && (paddr == timer8_pkg::OFF_CTRL_A);
  assign wr_ctrl_b = wr_fire && (paddr == timer8_pkg::OFF_CTRL_B);
  assign wr_count = wr_fire && (paddr == timer8_pkg::OFF_COUNT);
  assign wr_cmp_a = wr_fire && (paddr == timer8_pkg::OFF_CMP_A);
  assign wr_cmp_b = wr_fire && (paddr == timer8_pkg::OFF_CMP_B);
  assign wr_mask = wr_fire && (paddr == timer8_pkg::OFF_MASK);
  assign wr_flag = wr_fire && (paddr == timer8_pkg::OFF_FLAG);
  assign wr_power = wr_fire && (paddr == timer8_pkg::OFF_POWER);

  always_comb begin
    case (paddr)
      timer8_pkg::OFF_CTRL_A, timer8_pkg::OFF_CTRL_B, timer8_pkg::OFF_COUNT,
      timer8_pkg::OFF_CMP_A, timer8_pkg::OFF_CMP_B, timer8_pkg::OFF_MASK,
      timer8_pkg::OFF_FLAG, timer8_pkg::OFF_POWER: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // ****************************************
  // wave mode decode
  // ****************************************
  logic [2:0] wave_mode_field;
  timer8_pkg::wave_kind_t kind;
  logic [7:0] cmp_a_active;
  logic [7:0] cmp_b_active;
  logic [7:0] cmp_a_view;
  logic [7:0] cmp_b_view;
  logic [7:0] top_val;
  logic at_top;
  logic at_bottom;

  assign wave_mode_field = {wave_mode_bit2_r, ctrl_a_r[timer8_pkg::CTRL_A_WAVE_LO +: 2]};

  always_comb begin
    case (wave_mode_field[1:0])
      2'h1: kind = timer8_pkg::KIND_PHASE;
      2'h2: kind = timer8_pkg::KIND_CTC;
      2'h3: kind = timer8_pkg::KIND_FAST;
      default: kind = timer8_pkg::KIND_NORMAL;
    endcase
  end

  assign top_val = (kind == timer8_pkg::KIND_CTC || wave_mode_field[2]) ? cmp_a_active : timer8_pkg::COUNT_MAX;
  assign at_top = (count_value_r == top_val);
  assign at_bottom = (count_value_r == timer8_pkg::COUNT_BOTTOM);

  // ****************************************
  // clock select and timer tick
  // ****************************************
  logic timer_tick;
  logic run;

  // external pin: two stages, then an edge detect on the settled copy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_meta_r <= 1'b0;
      ext_sync_r <= 1'b0;
      ext_prev_r <= 1'b0;
    end else if (clk_en) begin
      ext_meta_r <= ext_count_input;
      ext_sync_r <= ext_meta_r;
      ext_prev_r <= ext_sync_r;
    end
  end

  assign run = (clock_select_field_r != timer8_pkg::CS_STOP) && !timer_power_reduce_bit_r;

  // prescaler free runs only while the timer runs, so the first tick is a whole period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r <= '0;
    end else if (clk_en) begin
      pre_r <= run ? pre_r + 10'h001 : '0;
    end
  end

  always_comb begin
    case (clock_select_field_r)
      timer8_pkg::CS_DIV1: timer_tick = 1'b1;
      timer8_pkg::CS_DIV8: timer_tick = (pre_r & timer8_pkg::PRE_MASK_8) == timer8_pkg::PRE_MASK_8;
      timer8_pkg::CS_DIV64: timer_tick = (pre_r & timer8_pkg::PRE_MASK_64) == timer8_pkg::PRE_MASK_64;
      timer8_pkg::CS_DIV256: timer_tick = (pre_r & timer8_pkg::PRE_MASK_256) == timer8_pkg::PRE_MASK_256;
      timer8_pkg::CS_DIV1024: timer_tick = pre_r == timer8_pkg::PRE_MASK_1024;
      timer8_pkg::CS_EXT_FALL: timer_tick = !ext_sync_r && ext_prev_r;
      timer8_pkg::CS_EXT_RISE: timer_tick = ext_sync_r && !ext_prev_r;
      default: timer_tick = 1'b0;
    endcase
    timer_tick = timer_tick && run;
  end

  // ****************************************
  // counter unit
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_value_r <= timer8_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (wr_count) begin
        count_value_r <= pwdata[7:0];
      end else if (timer_tick) begin
        case (kind)
          timer8_pkg::KIND_CTC, timer8_pkg::KIND_FAST:
            count_value_r <= at_top ? timer8_pkg::COUNT_BOTTOM : count_value_r + 8'h01;
          timer8_pkg::KIND_PHASE:
            if (down_r) begin
              count_value_r <= at_bottom ? count_value_r + 8'h01 : count_value_r - 8'h01;
            end else begin
              count_value_r <= at_top ? count_value_r - 8'h01 : count_value_r + 8'h01;
            end
          default: count_value_r <= count_value_r + 8'h01;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      down_r <= 1'b0;
    end else if (clk_en) begin
      if (kind != timer8_pkg::KIND_PHASE) begin
        down_r <= 1'b0;
      end else if (timer_tick && !wr_count) begin
        if (!down_r && at_top) begin
          down_r <= 1'b1;
        end else if (down_r && at_bottom) begin
          down_r <= 1'b0;
        end
      end
    end
  end

  // a count write arms the block; the next tick consumes it even if stopped meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      block_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_count) begin
        block_r <= 1'b1;
      end else if (timer_tick) begin
        block_r <= 1'b0;
      end
    end
  end

  // ****************************************
  // compare channels
  // ****************************************
  timer8_pkg::count_evt_t evt;
  timer8_pkg::chan_cfg_t cfg_a;
  timer8_pkg::chan_cfg_t cfg_b;
  logic load_buf;
  logic ovf_set;
  logic hit_a;
  logic hit_b;
  logic state_a;
  logic state_b;
  logic tick_eff;

  assign tick_eff = timer_tick && !wr_count;
  assign evt = '{tick: tick_eff, top: at_top, down: down_r};
  assign cfg_a = '{kind: kind, com: ctrl_a_r[timer8_pkg::CTRL_A_COM_A +: 2]};
  assign cfg_b = '{kind: kind, com: ctrl_a_r[timer8_pkg::CTRL_A_COM_B +: 2]};
  // fast pwm reloads as the count wraps to bottom, phase correct at top
  assign load_buf = tick_eff && at_top && (kind == timer8_pkg::KIND_FAST || !down_r);

  compare_channel #(.WIDTH(WIDTH)) chan_a (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cfg(cfg_a),
    .cpu_wr(wr_cmp_a),
    .cpu_wdata(pwdata[7:0]),
    .load_buf(load_buf),
    .count(count_value_r),
    .evt(evt),
    .block(block_r),
    .force_cmp(wr_ctrl_b && pwdata[timer8_pkg::CTRL_B_FORCE_A]),
    .active(cmp_a_active),
    .cpu_view(cmp_a_view),
    .hit(hit_a),
    .state(state_a)
  );

  compare_channel #(.WIDTH(WIDTH)) chan_b (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .cfg(cfg_b),
    .cpu_wr(wr_cmp_b),
    .cpu_wdata(pwdata[7:0]),
    .load_buf(load_buf),
    .count(count_value_r),
    .evt(evt),
    .block(block_r),
    .force_cmp(wr_ctrl_b && pwdata[timer8_pkg::CTRL_B_FORCE_B]),
    .active(cmp_b_active),
    .cpu_view(cmp_b_view),
    .hit(hit_b),
    .state(state_b)
  );

  always_comb begin
    case (kind)
      timer8_pkg::KIND_FAST: ovf_set = tick_eff && at_top;
      timer8_pkg::KIND_PHASE: ovf_set = tick_eff && down_r && at_bottom;
      default: ovf_set = tick_eff && (count_value_r == timer8_pkg::COUNT_MAX);
    endcase
  end

  // ****************************************
  // flags, mask and requests
  // ****************************************
  always_comb begin
    irq_flag_nxt = irq_flag_reg_r & ~irq_ack;
    if (wr_flag) begin
      irq_flag_nxt = irq_flag_nxt & ~pwdata[2:0];
    end
    // a new event wins over a clear in the same cycle
    irq_flag_nxt[timer8_pkg::IRQ_OVF] = irq_flag_nxt[timer8_pkg::IRQ_OVF] | ovf_set;
    irq_flag_nxt[timer8_pkg::IRQ_CMP_A] = irq_flag_nxt[timer8_pkg::IRQ_CMP_A] | hit_a;
    irq_flag_nxt[timer8_pkg::IRQ_CMP_B] = irq_flag_nxt[timer8_pkg::IRQ_CMP_B] | hit_b;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_flag_reg_r <= '0;
      irq_req_r <= '0;
    end else if (clk_en) begin
      irq_flag_reg_r <= irq_flag_nxt;
      irq_req_r <= irq_flag_nxt & irq_mask_reg_r & ~irq_ack;
    end
  end

  // ****************************************
  // software registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_a_r <= timer8_pkg::RST_BYTE;
      clock_select_field_r <= timer8_pkg::CS_STOP;
      wave_mode_bit2_r <= 1'b0;
      irq_mask_reg_r <= '0;
      timer_power_reduce_bit_r <= 1'b0;
    end else if (clk_en) begin
      if (wr_ctrl_a) begin
        ctrl_a_r <= pwdata[7:0];
      end
      if (wr_ctrl_b) begin
        clock_select_field_r <= pwdata[timer8_pkg::CTRL_B_CLKSEL +: 3];
        wave_mode_bit2_r <= pwdata[timer8_pkg::CTRL_B_WAVE_HI];
      end
      if (wr_mask) begin
        irq_mask_reg_r <= pwdata[2:0];
      end
      if (wr_power) begin
        timer_power_reduce_bit_r <= pwdata[timer8_pkg::POWER_REDUCE];
      end
    end
  end

  // ****************************************
  // apb answer: data latched in setup, pready high in the first access cycle
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_r <= '0;
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
    end else if (clk_en) begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      if (setup && !pwrite) begin
        case (paddr)
          timer8_pkg::OFF_CTRL_A: prdata_r <= {24'h000000, ctrl_a_r};
          timer8_pkg::OFF_CTRL_B: prdata_r <= {28'h0000000, wave_mode_bit2_r, clock_select_field_r};
          timer8_pkg::OFF_COUNT: prdata_r <= {24'h000000, count_value_r};
          timer8_pkg::OFF_CMP_A: prdata_r <= {24'h000000, cmp_a_view};
          timer8_pkg::OFF_CMP_B: prdata_r <= {24'h000000, cmp_b_view};
          timer8_pkg::OFF_MASK: prdata_r <= {29'h00000000, irq_mask_reg_r};
          timer8_pkg::OFF_FLAG: prdata_r <= {29'h00000000, irq_flag_reg_r};
          timer8_pkg::OFF_POWER: prdata_r <= {31'h00000000, timer_power_reduce_bit_r};
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  // ****************************************
  // pins: any nonzero compare output mode overrides the port
  // ****************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wave_oe_a_r <= 1'b0;
      wave_oe_b_r <= 1'b0;
    end else if (clk_en) begin
      wave_oe_a_r <= cfg_a.com != timer8_pkg::COM_NONE;
      wave_oe_b_r <= cfg_b.com != timer8_pkg::COM_NONE;
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign irq_req = irq_req_r;
  assign wave_out_a = state_a;
  assign wave_out_b = state_b;
  assign wave_oe_a = wave_oe_a_r;
  assign wave_oe_b = wave_oe_b_r;

endmodule : timer8_dual_compare_pwm

// *** src/timer8_pkg.sv ***
// shared constants and types of the 8-bit dual compare timer
package timer8_pkg;

  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_CTRL_A = 8'h00;
  localparam logic [7:0] OFF_CTRL_B = 8'h04;
  localparam logic [7:0] OFF_COUNT = 8'h08;
  localparam logic [7:0] OFF_CMP_A = 8'h0c;
  localparam logic [7:0] OFF_CMP_B = 8'h10;
  localparam logic [7:0] OFF_MASK = 8'h14;
  localparam logic [7:0] OFF_FLAG = 8'h18;
  localparam logic [7:0] OFF_POWER = 8'h1c;

  // ****************************************
  // field positions
  // ****************************************
  localparam int CTRL_A_WAVE_LO = 0;
  localparam int CTRL_A_COM_B = 4;
  localparam int CTRL_A_COM_A = 6;
  localparam int CTRL_B_CLKSEL = 0;
  localparam int CTRL_B_WAVE_HI = 3;
  localparam int CTRL_B_FORCE_B = 6;
  localparam int CTRL_B_FORCE_A = 7;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_CMP_A = 1;
  localparam int IRQ_CMP_B = 2;
  localparam int POWER_REDUCE = 0;

  // ****************************************
  // reset values and count limits
  // ****************************************
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] COUNT_BOTTOM = 8'h00;
  localparam logic [7:0] COUNT_MAX = 8'hff;

  // ****************************************
  // encodings
  // ****************************************
  localparam logic [2:0] WAVE_NORMAL = 3'h0;
  localparam logic [2:0] WAVE_CTC = 3'h2;
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] PRE_MASK_8 = 10'h007;
  localparam logic [9:0] PRE_MASK_64 = 10'h03f;
  localparam logic [9:0] PRE_MASK_256 = 10'h0ff;
  localparam logic [9:0] PRE_MASK_1024 = 10'h3ff;
  localparam logic [1:0] COM_NONE = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;

  typedef enum logic [3:0] {
    KIND_NORMAL = 4'b0001,
    KIND_CTC = 4'b0010,
    KIND_FAST = 4'b0100,
    KIND_PHASE = 4'b1000
  } wave_kind_t;

  typedef struct packed {
    wave_kind_t kind;
    logic [1:0] com;
  } chan_cfg_t;

  typedef struct packed {
    logic tick;
    logic top;
    logic down;
  } count_evt_t;

endpackage : timer8_pkg

// *** src/compare_channel.sv ***
// one output compare channel: buffer, active compare, match and output state
`timescale 1ns/1ns
module compare_channel #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input timer8_pkg::chan_cfg_t cfg,
  input wire logic cpu_wr,
  input wire logic [WIDTH-1:0] cpu_wdata,
  input wire logic load_buf,
  input wire logic [WIDTH-1:0] count,
  input timer8_pkg::count_evt_t evt,
  input wire logic block,
  input wire logic force_cmp,
  output logic [WIDTH-1:0] active,
  output logic [WIDTH-1:0] cpu_view,
  output logic hit,
  output logic state
);

  initial begin
    if (WIDTH < 1 || WIDTH > 8) $error("compare_channel: WIDTH must be 1..8");
  end

  logic [WIDTH-1:0] buf_r;
  logic [WIDTH-1:0] active_r;
  logic state_r;
  logic buffered;
  logic non_pwm;
  logic nonpwm_val;

  assign buffered = (cfg.kind == timer8_pkg::KIND_FAST) || (cfg.kind == timer8_pkg::KIND_PHASE);
  assign non_pwm = !buffered;
  assign cpu_view = buffered ? buf_r : active_r;
  assign active = active_r;
  assign hit = evt.tick && (count == active_r) && !block;
  assign state = state_r;

  always_comb begin
    case (cfg.com)
      timer8_pkg::COM_TOGGLE: nonpwm_val = !state_r;
      timer8_pkg::COM_CLEAR: nonpwm_val = 1'b0;
      timer8_pkg::COM_SET: nonpwm_val = 1'b1;
      default: nonpwm_val = state_r;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      buf_r <= '0;
      active_r <= '0;
    end else if (clk_en) begin
      if (cpu_wr) begin
        buf_r <= cpu_wdata;
      end
      if (cpu_wr && !buffered) begin
        active_r <= cpu_wdata;
      end else if (buffered && load_buf) begin
        active_r <= buf_r;
      end
    end
  end

  // com changes act at once; state kept across mode switches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= 1'b0;
    end else if (clk_en) begin
      if (force_cmp && non_pwm) begin
        state_r <= nonpwm_val;
      end else if (cfg.kind == timer8_pkg::KIND_FAST && evt.tick && evt.top && cfg.com[1]) begin
        state_r <= !cfg.com[0];
      end else if (hit && cfg.com[1]) begin
        if (cfg.kind == timer8_pkg::KIND_PHASE) begin
          state_r <= cfg.com[0] ^ evt.down;
        end else begin
          state_r <= non_pwm ? nonpwm_val : cfg.com[0];
        end
      end else if (hit && non_pwm) begin
        state_r <= nonpwm_val;
      end
    end
  end

endmodule : compare_channel

// *** tb/timer8_checker.sv ***
// concurrent checks on the timer's register port and interrupt pins
`timescale 1ns/1ns
module timer8_checker #(
  parameter int WIDTH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [2:0] irq_ack,
  input wire logic [2:0] irq_req,
  input wire logic wave_oe_a
);
  // ***
  // bus and pin relations
  // ***
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_wr(logic [7:0] a);
    psel && penable && pready && pwrite && paddr == a;
  endsequence
  a_ready_after_setup: assert property (psel && !penable && clk_en |=> pready)
    else $error("no ready after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error without ready");
  a_err_on_hole: assert property (psel && !penable && (paddr[1:0] != 2'h0 || paddr > timer8_pkg::OFF_POWER)
    |=> pslverr)
    else $error("unmapped access not refused");
  a_upper_read_zero: assert property (pready && !pwrite |-> prdata[31:WIDTH] == '0)
    else $error("upper read bits set");
  a_oe_follows_mode: assert property (s_wr(timer8_pkg::OFF_CTRL_A) |-> ##2
    (wave_oe_a == ($past(pwdata[7:6], 2) != 2'h0)))
    else $error("output enable not following mode");
  a_mask_gates_req: assert property (s_wr(timer8_pkg::OFF_MASK) ##0 pwdata[2:0] == 3'h0 |-> ##2
    irq_req == 3'h0)
    else $error("masked request raised");
  a_ack_drops_req: assert property (irq_ack != 3'h0 |=> (irq_req & $past(irq_ack)) == 3'h0)
    else $error("request kept after service");
endmodule : timer8_checker

// *** tb/irq_server.sv ***
// interrupt servicing side: answers pending requests with an acknowledge pulse
`timescale 1ns/1ns
module irq_server (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [3:0] delay,
  input wire logic [2:0] irq_req,
  output logic [2:0] irq_ack
);
  logic [3:0] wait_r;
  // latency is set once by the bench from a random value; a request raised while another waits is acknowledged with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_r <= 4'h0;
      irq_ack <= 3'h0;
    end else if (irq_req != 3'h0 && irq_ack == 3'h0) begin
      wait_r <= wait_r + 4'h1;
      if (wait_r >= delay) begin
        irq_ack <= irq_req;
        wait_r <= 4'h0;
      end
    end else begin
      irq_ack <= 3'h0;
    end
  end
endmodule : irq_server

// *** tb/tb_timer8_dual_compare_pwm.sv ***
// self-checking bench for the dual compare timer
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_count++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb_timer8_dual_compare_pwm;
  typedef struct packed {
    logic ck;
    logic e;
    logic [31:0] d;
  } note_t;
  logic pclk, presetn, clk_en, psel, penable, pwrite, ext_count_input;
  logic pready, pslverr, wave_out_a, wave_out_b, wave_oe_a, wave_oe_b;
  logic [7:0] paddr, v;
  logic [31:0] pwdata, prdata;
  logic [2:0] irq_ack, irq_req;
  logic [3:0] delay;
  int err_count, n_tests;
  note_t notes[$];
  note_t n;
  timer8_dual_compare_pwm #(.WIDTH(8)) u_dut (.pclk, .presetn, .clk_en, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .ext_count_input, .irq_ack, .irq_req, .wave_out_a, .wave_out_b,
    .wave_oe_a, .wave_oe_b);
  irq_server u_irq (.pclk, .presetn, .delay, .irq_req, .irq_ack);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ***
  // bus tasks and result watcher
  // ***
  task automatic end_of_test();
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d, input logic ck, input logic e);
    int i;
    notes.push_back('{ck, e, {24'h0, d}});
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= w ? {24'($urandom), d} : $urandom;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (!pready && i < 20);
    if (!pready) begin
      err_count++;
      end_of_test();
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b1, a, d, 1'b0, 1'b0);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] d);
    xfer(1'b0, a, d, 1'b1, 1'b0);
  endtask : rd
  task automatic run(input int c);
    wr(timer8_pkg::OFF_CTRL_B, {5'h0, timer8_pkg::CS_DIV1});
    repeat (c) @(posedge pclk);
    wr(timer8_pkg::OFF_CTRL_B, 8'h00);
  endtask : run
  always @(posedge pclk) begin
    if (psel && penable && pready) begin
      n = notes.pop_front();
      `CHK("pslverr", n.e, pslverr)
      if (n.ck) `CHK("prdata", n.d, prdata)
    end
  end
  // ***
  // scenarios
  // ***
  initial begin
    presetn = 1'b0;
    clk_en = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    ext_count_input = 1'b0;
    err_count = 0;
    n_tests = 0;
    void'($urandom(61862));
    delay = 4'($urandom);
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int a = 0; a < 32; a += 4) rd(8'(a), 8'h00);
    xfer(1'b0, 8'h20, 8'h00, 1'b1, 1'b1);
    xfer(1'b1, 8'h22, 8'h5a, 1'b0, 1'b1);
    wr(timer8_pkg::OFF_CMP_A, 8'h40);
    wr(timer8_pkg::OFF_CMP_B, 8'h60);
    v = 8'($urandom);
    wr(timer8_pkg::OFF_COUNT, v);
    repeat (5) @(posedge pclk);
    rd(timer8_pkg::OFF_COUNT, v);
    wr(timer8_pkg::OFF_POWER, 8'h01);
    wr(timer8_pkg::OFF_CTRL_B, 8'h01);
    repeat (5) @(posedge pclk);
    rd(timer8_pkg::OFF_COUNT, v);
    wr(timer8_pkg::OFF_CTRL_B, 8'h00);
    wr(timer8_pkg::OFF_POWER, 8'h00);
    wr(timer8_pkg::OFF_COUNT, 8'hfe);
    run(20);
    rd(timer8_pkg::OFF_FLAG, 8'h01);
    wr(timer8_pkg::OFF_FLAG, 8'h06);
    rd(timer8_pkg::OFF_FLAG, 8'h01);
    wr(timer8_pkg::OFF_FLAG, 8'h01);
    rd(timer8_pkg::OFF_FLAG, 8'h00);
    // count written equal to compare a on purpose: that match must be lost
    wr(timer8_pkg::OFF_COUNT, 8'h40);
    run(10);
    rd(timer8_pkg::OFF_FLAG, 8'h00);
    wr(timer8_pkg::OFF_COUNT, 8'h3e);
    run(20);
    rd(timer8_pkg::OFF_FLAG, 8'h02);
    wr(timer8_pkg::OFF_CTRL_A, 8'h02);
    wr(timer8_pkg::OFF_COUNT, 8'h00);
    wr(timer8_pkg::OFF_CMP_A, 8'h10);
    wr(timer8_pkg::OFF_FLAG, 8'h07);
    run(100);
    rd(timer8_pkg::OFF_FLAG, 8'h02);
    rd(timer8_pkg::OFF_COUNT, 8'h01);
    `CHK("wave_out_a", 1'b0, wave_out_a)
    wr(timer8_pkg::OFF_FLAG, 8'h07);
    // force is how software should preset the output after enabling it
    wr(timer8_pkg::OFF_CTRL_A, 8'h50);
    for (int k = 0; k < 3; k++) begin
      wr(timer8_pkg::OFF_CTRL_B, 8'hc0);
      repeat (2) @(posedge pclk);
      `CHK("wave_out_a", ~k[0], wave_out_a)
      `CHK("wave_out_b", ~k[0], wave_out_b)
    end
    wr(timer8_pkg::OFF_CTRL_A, 8'h43);
    repeat (2) @(posedge pclk);
    `CHK("wave_out_a", 1'b1, wave_out_a)
    `CHK("wave_oe_b", 1'b0, wave_oe_b)
    wr(timer8_pkg::OFF_CTRL_B, 8'h80);
    repeat (2) @(posedge pclk);
    `CHK("wave_out_a", 1'b1, wave_out_a)
    rd(timer8_pkg::OFF_FLAG, 8'h00);
    wr(timer8_pkg::OFF_CMP_B, 8'h20);
    wr(timer8_pkg::OFF_COUNT, 8'h1e);
    run(12);
    rd(timer8_pkg::OFF_FLAG, 8'h00);
    rd(timer8_pkg::OFF_CMP_B, 8'h20);
    for (int m = 7; m >= 0; m -= 7) begin
      wr(timer8_pkg::OFF_FLAG, 8'h07);
      wr(timer8_pkg::OFF_MASK, 8'(m));
      wr(timer8_pkg::OFF_COUNT, 8'hfe);
      run(40);
      repeat (20) @(posedge pclk);
      rd(timer8_pkg::OFF_FLAG, m == 7 ? 8'h00 : 8'h07);
      `CHK("irq_req", 3'h0, irq_req)
    end
    // phase correct: up through 0xff, then back down
    wr(timer8_pkg::OFF_CTRL_A, 8'h01);
    wr(timer8_pkg::OFF_COUNT, 8'hfd);
    run(7);
    rd(timer8_pkg::OFF_COUNT, 8'hf7);
    wr(timer8_pkg::OFF_CTRL_A, 8'h00);
    wr(timer8_pkg::OFF_COUNT, 8'h00);
    wr(timer8_pkg::OFF_CTRL_B, {5'h0, timer8_pkg::CS_EXT_RISE});
    repeat (5) begin
      ext_count_input <= 1'b1;
      repeat (4) @(posedge pclk);
      ext_count_input <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    wr(timer8_pkg::OFF_CTRL_B, 8'h00);
    rd(timer8_pkg::OFF_COUNT, 8'h05);
    // clock enable low must freeze the running count
    wr(timer8_pkg::OFF_CTRL_B, {5'h0, timer8_pkg::CS_DIV1});
    clk_en <= 1'b0;
    repeat (10) @(posedge pclk);
    clk_en <= 1'b1;
    wr(timer8_pkg::OFF_CTRL_B, 8'h00);
    rd(timer8_pkg::OFF_COUNT, 8'h08);
    wr(timer8_pkg::OFF_CTRL_B, {5'h0, timer8_pkg::CS_DIV8});
    repeat (20) @(posedge pclk);
    wr(timer8_pkg::OFF_CTRL_B, 8'h00);
    rd(timer8_pkg::OFF_COUNT, 8'h0a);
    repeat (2) @(posedge pclk);
    end_of_test();
  end
endmodule : tb_timer8_dual_compare_pwm
bind timer8_dual_compare_pwm timer8_checker #(.WIDTH(WIDTH)) u_chk (.pclk, .presetn, .clk_en, .psel, .penable,
  .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq_ack, .irq_req, .wave_oe_a);
